// File: wwd_pkg.sv
// package: constants and carrier types of the windowed watchdog
package wwd_pkg;

  localparam int unsigned CNT_W         = 24;
  localparam int unsigned ADDR_W        = 12;

  // register byte offsets
  localparam logic [11:0] OFF_MODE      = 12'h000;
  localparam logic [11:0] OFF_RELOAD    = 12'h004;
  localparam logic [11:0] OFF_FEED      = 12'h008;
  localparam logic [11:0] OFF_VALUE     = 12'h00C;
  localparam logic [11:0] OFF_CLKSEL    = 12'h010;
  localparam logic [11:0] OFF_WARN      = 12'h014;
  localparam logic [11:0] OFF_WINDOW    = 12'h018;

  // mode and clock-select register field positions
  localparam int unsigned MODE_EN_BIT   = 0;
  localparam int unsigned MODE_RST_BIT  = 1;
  localparam int unsigned MODE_TOF_BIT  = 2;
  localparam int unsigned MODE_WARN_BIT = 3;
  localparam int unsigned MODE_PROT_BIT = 4;
  localparam int unsigned CLKSEL_BIT    = 0;

  // reset values and limits
  localparam logic [23:0] RELOAD_MIN    = 24'h0000FF;
  localparam logic [23:0] RELOAD_RST    = 24'h0000FF;
  localparam logic [23:0] VALUE_RST     = 24'h0000FF;
  localparam logic [23:0] WINDOW_RST    = 24'hFFFFFF;
  localparam logic [23:0] WARN_RST      = 24'h000000;
  localparam logic [7:0]  FEED_FIRST    = 8'hAA;
  localparam logic [7:0]  FEED_SECOND   = 8'h55;

  // fixed divide-by-4 prescaler on the count clock
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;
  // count-domain write latency in count-clock cycles
  localparam int unsigned SYNC_STAGES   = 3;

  // count clock: two selectable sources derived from sys_clk
  localparam int unsigned SYS_CLK_NS    = 4;
  localparam int unsigned CNT_A_NS      = 16;
  localparam int unsigned CNT_B_NS      = 40;
  localparam int unsigned DIV_W         = 4;
  localparam logic [3:0]  DIV_A_LAST    = 4'((CNT_A_NS + SYS_CLK_NS - 1) / SYS_CLK_NS - 1);
  localparam logic [3:0]  DIV_B_LAST    = 4'((CNT_B_NS + SYS_CLK_NS - 1) / SYS_CLK_NS - 1);

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wwd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wwd_apb_rsp_t;

  typedef enum logic {
    FEED_IDLE,
    FEED_ARMED
  } wwd_feed_t;

endpackage : wwd_pkg

// File: wwd_tick_gen.sv
// count-clock enable and divide-by-4 prescaled tick
`timescale 1ns/1ns
module wwd_tick_gen (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clkSrc,
  output logic      countTick,
  output logic      preTick
);

  typedef struct packed {
    logic [3:0] div;
    logic [1:0] pre;
    logic       countTick;
    logic       preTick;
  } wwd_tick_state_t;

  wwd_tick_state_t s_q;
  wwd_tick_state_t s_d;
  logic [3:0]      divLast;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    divLast       = clkSrc ? wwd_pkg::DIV_B_LAST : wwd_pkg::DIV_A_LAST;
    s_d           = s_q;
    s_d.countTick = 1'b0;
    s_d.preTick   = 1'b0;
    if (s_q.div >= divLast)
    begin
      s_d.div       = 4'h0;
      s_d.countTick = 1'b1;
      s_d.pre       = s_q.pre + 2'h1;
      s_d.preTick   = (s_q.pre == wwd_pkg::PRESCALE_LAST);
    end
    else
    begin
      s_d.div = s_q.div + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign countTick = s_q.countTick;
  assign preTick   = s_q.preTick;

endmodule : wwd_tick_gen

// File: wwd_watchdog.sv
// windowed watchdog: apb registers, feed sequencer, counter and readback
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
//
// Behaviour
// - 24-bit counter decrements per divide-by-4 tick
// - reload below 0xFF replaced by 0xFF
// - timeout 1020 to 2^26-4 count clocks, step four
// - 0xAA then 0x55 reloads and starts counter
// - reaching zero without feed raises event
// - feed above window value raises event
// - event resets chip only if reset enabled
// - bad feed sequence raises event when enabled
// - warning flag when counter equals warning value
// - timeout flag stays until software clears it
// - enable cannot be cleared by software
// - clock source locked once enabled
// - protected reload changes only after warning time
// - mode and reload reach count side after three
// - counter captured then synchronised for readback
// - registers over apb, counting on count clock
// - enable bit0, reset bit1, both set-only
// - timeout flag bit2, warning flag bit3
// - protect bit4 set-only, below warning and window
// - window resets all ones, warning resets zero
module wwd_watchdog (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire wwd_pkg::wwd_apb_req_t apbReq,
  output wwd_pkg::wwd_apb_rsp_t      apbRsp,
  output logic                       chipReset,
  output logic                       warnIrq
);

  typedef struct packed {
    logic                  en;
    logic                  rstEn;
    logic                  protect;
    logic                  timeoutFlag;
    logic                  warnFlag;
    logic                  clkSrc;
    logic                  running;
    logic [23:0]           reload;
    logic [23:0]           warn;
    logic [23:0]           window;
    logic [23:0]           count;
    logic [2:0][23:0]      reloadPipe;
    logic [2:0][1:0]       modePipe;
    wwd_pkg::wwd_feed_t    feed;
    logic [23:0]           capture;
    logic [23:0]           sync1;
    logic [23:0]           sync2;
    wwd_pkg::wwd_apb_rsp_t rsp;
    logic                  chipReset;
    logic                  warnIrq;
  } wwd_state_t;

  wwd_state_t  s_q;
  wwd_state_t  s_d;
  logic        countTick;
  logic        preTick;
  logic        acc;
  logic        wr;
  logic        feedOk;
  logic        wdEvent;
  logic [23:0] wdata;
  logic [23:0] nextCount;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == wwd_pkg::OFF_MODE) || (a == wwd_pkg::OFF_RELOAD) || (a == wwd_pkg::OFF_FEED) ||
               (a == wwd_pkg::OFF_VALUE) || (a == wwd_pkg::OFF_CLKSEL) || (a == wwd_pkg::OFF_WARN) ||
               (a == wwd_pkg::OFF_WINDOW);
  endfunction : isMapped

  function automatic logic isFeedWrite(input wwd_pkg::wwd_apb_req_t r, input logic [7:0] v);
    isFeedWrite = r.pwrite && (r.paddr == wwd_pkg::OFF_FEED) && (r.pwdata[7:0] == v);
  endfunction : isFeedWrite

  wwd_tick_gen u_tick (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clkSrc    (s_q.clkSrc),
    .countTick (countTick),
    .preTick   (preTick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d         = s_q;
    s_d.chipReset = 1'b0;
    acc         = apbReq.psel && apbReq.penable && s_q.rsp.pready;
    wr          = acc && apbReq.pwrite;
    wdata       = apbReq.pwdata[23:0];
    feedOk      = 1'b0;
    wdEvent     = 1'b0;
    nextCount   = s_q.count - 24'h000001;

    // answer one cycle into the access phase; data prepared alongside pready
    s_d.rsp.pready  = apbReq.psel && apbReq.penable && !s_q.rsp.pready;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata  = 32'h00000000;
    if (s_d.rsp.pready)
    begin
      s_d.rsp.pslverr = !isMapped(apbReq.paddr);
      case (apbReq.paddr)
        wwd_pkg::OFF_MODE:   s_d.rsp.prdata = {27'h0000000, s_q.protect, s_q.warnFlag, s_q.timeoutFlag,
                                               s_q.rstEn, s_q.en};
        wwd_pkg::OFF_RELOAD: s_d.rsp.prdata = {8'h00, s_q.reload};
        wwd_pkg::OFF_VALUE:  s_d.rsp.prdata = {8'h00, s_q.sync2};
        wwd_pkg::OFF_CLKSEL: s_d.rsp.prdata = {31'h00000000, s_q.clkSrc};
        wwd_pkg::OFF_WARN:   s_d.rsp.prdata = {8'h00, s_q.warn};
        wwd_pkg::OFF_WINDOW: s_d.rsp.prdata = {8'h00, s_q.window};
        default:             s_d.rsp.prdata = 32'h00000000;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // feed sequencer: once armed, the very next access must be the second byte
    case (s_q.feed)
      wwd_pkg::FEED_IDLE:
      begin
        if (acc && isFeedWrite(apbReq, wwd_pkg::FEED_FIRST))
          s_d.feed = wwd_pkg::FEED_ARMED;
      end
      wwd_pkg::FEED_ARMED:
      begin
        if (acc)
        begin
          s_d.feed = wwd_pkg::FEED_IDLE;
          if (isFeedWrite(apbReq, wwd_pkg::FEED_SECOND))
            feedOk = 1'b1;
          else if (s_q.en)
            wdEvent = 1'b1;
        end
      end
      default: s_d.feed = wwd_pkg::FEED_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////////
    // register writes
    if (wr)
    begin
      case (apbReq.paddr)
        wwd_pkg::OFF_MODE:
        begin
          // set-only bits, flags write-one-to-clear
          s_d.en      = s_q.en | apbReq.pwdata[wwd_pkg::MODE_EN_BIT];
          s_d.rstEn   = s_q.rstEn | apbReq.pwdata[wwd_pkg::MODE_RST_BIT];
          s_d.protect = s_q.protect | apbReq.pwdata[wwd_pkg::MODE_PROT_BIT];
          if (apbReq.pwdata[wwd_pkg::MODE_TOF_BIT])
            s_d.timeoutFlag = 1'b0;
          if (apbReq.pwdata[wwd_pkg::MODE_WARN_BIT])
            s_d.warnFlag = 1'b0;
        end
        wwd_pkg::OFF_RELOAD:
        begin
          if (!s_q.protect || ((s_q.count < s_q.warn) && (s_q.count < s_q.window)))
            s_d.reload = (wdata < wwd_pkg::RELOAD_MIN) ? wwd_pkg::RELOAD_MIN : wdata;
          else
            wdEvent = 1'b1;
        end
        wwd_pkg::OFF_CLKSEL:
        begin
          if (!s_q.en)
            s_d.clkSrc = apbReq.pwdata[wwd_pkg::CLKSEL_BIT];
        end
        wwd_pkg::OFF_WARN:   s_d.warn = wdata;
        wwd_pkg::OFF_WINDOW: s_d.window = wdata;
        default:             s_d.warn = s_q.warn;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // count domain: settings ripple through three count-clock stages
    if (countTick)
    begin
      s_d.reloadPipe = {s_q.reloadPipe[1:0], s_q.reload};
      s_d.modePipe   = {s_q.modePipe[1:0], {s_q.rstEn, s_q.en}};
      s_d.capture    = s_q.count;
    end

    if (feedOk)
    begin
      // feed overrides a tick in the same cycle
      if (s_q.running && (s_q.count > s_q.window))
        wdEvent = 1'b1;
      s_d.count   = s_q.reloadPipe[wwd_pkg::SYNC_STAGES - 1];
      s_d.running = s_q.en;
    end
    else if (preTick && s_q.running && s_q.modePipe[wwd_pkg::SYNC_STAGES - 1][0])
    begin
      if (s_q.count <= 24'h000001)
      begin
        wdEvent   = 1'b1;
        s_d.count = s_q.reloadPipe[wwd_pkg::SYNC_STAGES - 1];
      end
      else
      begin
        s_d.count = nextCount;
        if (nextCount == s_q.warn)
          s_d.warnFlag = 1'b1;
      end
    end

    // readback synchroniser; first stage feeds only the second
    s_d.sync1 = s_q.capture;
    s_d.sync2 = s_q.sync1;

    //////////////////////////////////////////////////////////////////////////////
    // watchdog event: flag set wins over a clear in the same cycle
    if (wdEvent)
    begin
      s_d.timeoutFlag = 1'b1;
      if (s_q.modePipe[wwd_pkg::SYNC_STAGES - 1][1])
      begin
        // watchdog reset: the only path that disables the block besides rst_b
        s_d.chipReset = 1'b1;
        s_d.en        = 1'b0;
        s_d.rstEn     = 1'b0;
        s_d.protect   = 1'b0;
        s_d.running   = 1'b0;
        s_d.warnFlag  = 1'b0;
      end
    end
    s_d.warnIrq = s_d.warnFlag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q            <= '0;
      s_q.reload     <= wwd_pkg::RELOAD_RST;
      s_q.count      <= wwd_pkg::VALUE_RST;
      s_q.capture    <= wwd_pkg::VALUE_RST;
      s_q.sync1      <= wwd_pkg::VALUE_RST;
      s_q.sync2      <= wwd_pkg::VALUE_RST;
      s_q.reloadPipe <= {3{wwd_pkg::RELOAD_RST}};
      s_q.window     <= wwd_pkg::WINDOW_RST;
      s_q.warn       <= wwd_pkg::WARN_RST;
      s_q.feed       <= wwd_pkg::FEED_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apbRsp    = s_q.rsp;
  assign chipReset = s_q.chipReset;
  assign warnIrq   = s_q.warnIrq;

endmodule : wwd_watchdog

// File: wwd_props.sv
// checker: port-level assertions of the windowed watchdog
`timescale 1ns/1ns
module wwd_props (
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire wwd_pkg::wwd_apb_req_t apbReq,
  input wire wwd_pkg::wwd_apb_rsp_t apbRsp,
  input wire logic                  chipReset,
  input wire logic                  warnIrq
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic rdAck;
  logic mapped;
  assign rdAck  = apbRsp.pready && !apbReq.pwrite;
  assign mapped = apbReq.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
  ////////////////////////////////////////////////////////////
  a_ready_one_wait: assert property (apbReq.psel && $rose(apbReq.penable) |=> apbRsp.pready)
    else $error("pready not after one wait");
  a_ready_in_access: assert property (apbRsp.pready |-> apbReq.psel && $past(apbReq.penable))
    else $error("pready outside access");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready longer than one cycle");
  a_idle_quiet: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr)
    else $error("response without pready");
  a_err_decode: assert property (apbRsp.pready |-> apbRsp.pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_mode_spare: assert property (rdAck && apbReq.paddr == 12'h000 |-> apbRsp.prdata[31:5] == 27'h0)
    else $error("mode spare bits not zero");
  a_reload_floor: assert property (rdAck && apbReq.paddr == 12'h004 |-> apbRsp.prdata >= 32'h000000FF
    && apbRsp.prdata[31:24] == 8'h0)
    else $error("reload below floor");
  a_reset_pulse: assert property (chipReset |=> !chipReset)
    else $error("chipReset longer than one cycle");
endmodule : wwd_props

bind wwd_watchdog wwd_props i_props (
  .sys_clk   (sys_clk),
  .rst_b     (rst_b),
  .apbReq    (apbReq),
  .apbRsp    (apbRsp),
  .chipReset (chipReset),
  .warnIrq   (warnIrq)
);

// File: tb_wwd_watchdog.sv
// testbench: registers, feeds, window and protect of the watchdog
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_wwd_watchdog;
  logic                  sys_clk;
  logic                  rst_b;
  wwd_pkg::wwd_apb_req_t req;
  wwd_pkg::wwd_apb_rsp_t rsp;
  logic                  chipReset;
  logic                  warnIrq;
  logic [31:0]           rdat;
  logic                  rerr;
  int                    rstCnt;
  int                    checked;
  int                    miscompares;
  wwd_watchdog i_dut (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .apbReq    (req),
    .apbRsp    (rsp),
    .chipReset (chipReset),
    .warnIrq   (warnIrq)
  );
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (chipReset === 1'b1) rstCnt <= rstCnt + 1;
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1 && n < 16)
    begin
      @(posedge sys_clk);
      n++;
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    if (n == 16) end_sim;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic feed;
    wr(12'h008, {24'h0, wwd_pkg::FEED_FIRST});
    wr(12'h008, {24'h0, wwd_pkg::FEED_SECOND});
  endtask : feed
  task automatic do_reset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask : do_reset
  // count-side settings land after three count ticks; 16 cycles covers it
  task automatic settle;
    repeat (16) @(posedge sys_clk);
  endtask : settle
  task automatic wait_rst(input int exp);
    repeat (60) if (rstCnt != exp) @(posedge sys_clk);
    `CHK("chipReset pulses", exp, rstCnt);
    if (miscompares != 0) end_sim;
  endtask : wait_rst
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(12'h000);
    `CHK("mode", 32'h0, rdat);
    rd(12'h018);
    `CHK("window", 32'h00FFFFFF, rdat);
    rd(12'h014);
    `CHK("warn", 32'h0, rdat);
    rd(12'h00C);
    `CHK("value", 32'h000000FF, rdat);
    rd(12'h020);
    `CHK("unmapped", 1'b1, rerr);
    wr(12'h004, 32'h00000010);
    rd(12'h004);
    `CHK("reload clamp", 32'h000000FF, rdat);
    wr(12'h010, 32'h00000001);
    rd(12'h010);
    `CHK("clksel free", 1'b1, rdat[0]);
    wr(12'h010, 32'h00000000);
    rd(12'h010);
    `CHK("clksel back", 1'b0, rdat[0]);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_timeout;
    // order kept: reload, warning, mode, then feed
    wr(12'h004, 32'h00000120);
    wr(12'h014, 32'h00000080);
    wr(12'h000, 32'h00000001);
    settle;
    feed;
    wr(12'h000, 32'h0);
    rd(12'h000);
    `CHK("enable held", 1'b1, rdat[0]);
    wr(12'h010, 32'h1);
    rd(12'h010);
    `CHK("clksel locked", 1'b0, rdat[0]);
    rd(12'h00C);
    `CHK("reloaded", 1'b1, rdat[23:0] inside {[24'h11C:24'h120]});
    repeat (3000) if (warnIrq !== 1'b1) @(posedge sys_clk);
    `CHK("warnIrq", 1'b1, warnIrq);
    if (miscompares != 0) end_sim;
    rd(12'h00C);
    `CHK("value at warn", 1'b1, rdat[23:0] inside {[24'h7E:24'h81]});
    rd(12'h000);
    `CHK("flags early", 2'b10, rdat[3:2]);
    repeat (2000) if (rdat[2] !== 1'b1) rd(12'h000);
    `CHK("timeout flag", 1'b1, rdat[2]);
    `CHK("no chip reset", 0, rstCnt);
    wr(12'h000, 32'h00000004);
    rd(12'h000);
    `CHK("flag cleared", 1'b0, rdat[2]);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_bad_feed;
    do_reset;
    wr(12'h000, 32'h00000003);
    settle;
    wr(12'h008, {24'h0, wwd_pkg::FEED_FIRST});
    rd(12'h000);
    wait_rst(1);
    rd(12'h000);
    `CHK("mode after event", 5'h04, rdat[4:0]);
    $display("t_bad_feed done");
  endtask : t_bad_feed
  task automatic t_window;
    do_reset;
    wr(12'h018, 32'h00000080);
    wr(12'h000, 32'h00000003);
    settle;
    feed;
    settle;
    feed;
    wait_rst(2);
    $display("t_window done");
  endtask : t_window
  task automatic t_protect;
    do_reset;
    wr(12'h000, 32'h00000011);
    feed;
    wr(12'h004, 32'h00000200);
    rd(12'h004);
    `CHK("reload held", 32'h000000FF, rdat);
    rd(12'h000);
    `CHK("protect event", 2'b11, {rdat[4], rdat[2]});
    $display("t_protect done");
  endtask : t_protect
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    sys_clk = 1'b0;
    rst_b   = 1'b0;
    req     = '0;
    do_reset;
    t_regs;
    t_timeout;
    t_bad_feed;
    t_window;
    t_protect;
    end_sim;
  end
endmodule : tb_wwd_watchdog
